/* src/sbd_store_regs.vh */
// Constants of the byte and doubleword store address generator.
// Included by bare name; holds definitions only.
// How it works
// - Side bit picks the data unit and the base/offset file: 0 A, 1 B.
// - Byte stores add or subtract register or short offset unscaled.
// - Pre and plain offset modes send the computed address to memory.
// - Post modes send the old base and write the result back.
// - Linear by default; base 4 to 7 may be circular per mode register.
// - A byte store writes only the low eight bits of the source.
// - Source bit picks the store data file: 0 A, 1 B.
// - Store data may come from either file, whatever the unit or base.
// - Long form bases on the first or second fixed base by side bit.
// - The long form always runs on the side two data unit.
// - Long form adds the unscaled constant linearly, never circular.
// - A doubleword store writes one 64-bit register pair at once.
// - Doubleword offsets are shifted left by three before use.
`ifndef SBD_STORE_REGS_VH
`define SBD_STORE_REGS_VH

`define SBD_CREG_MSB 31
`define SBD_CREG_LSB 29
`define SBD_ZBIT 28
`define SBD_SRC_MSB 27
`define SBD_SRC_LSB 23
`define SBD_BASE_MSB 22
`define SBD_BASE_LSB 18
`define SBD_OFF_MSB 17
`define SBD_OFF_LSB 13
`define SBD_MODE_MSB 12
`define SBD_MODE_LSB 9
`define SBD_LCST_MSB 22
`define SBD_LCST_LSB 8
`define SBD_DWBIT 8
`define SBD_YBIT 7
`define SBD_OPC_MSB 6
`define SBD_OPC_LSB 2
`define SBD_SBIT 1

`define SBD_OPC_BYTE 5'h0d
`define SBD_OPC_DWORD 5'h11
`define SBD_OPC_LONG 5'h0f

`define SBD_MODE_REGOFF 2
`define SBD_MODE_ADD 0
`define SBD_MODE_MODIFY 3
`define SBD_MODE_POST 1

`define SBD_FIXED_BASE_FIRST 5'h0e
`define SBD_FIXED_BASE_SECOND 5'h0f
`define SBD_CIRC_BASE_HI 3'h1

`define SBD_DW_SHIFT 3
`define SBD_BYTE_SHIFT 0
`define SBD_AMR_LIN 2'h0
`define SBD_AMR_BK0 2'h1
`define SBD_AMR_BK1 2'h2
`define SBD_AMR_BK0_LSB 16
`define SBD_AMR_BK1_LSB 21

`define SBD_RST_ADDR 32'h00000000
`define SBD_RST_DATA 64'h0000000000000000
`define SBD_RST_BE 8'h00
`define SBD_BE_ALL 8'hff
`define SBD_BE_ONE 8'h01

`endif

/* src/sbd_cond_eval.v */
// Condition test of a store instruction.
// Assumes the core reports whether the register named by creg is zero.
`timescale 1ns/1ps
module sbd_cond_eval
(
    input wire [2:0] condField,
    input wire zeroTest,
    input wire condRegIsZero,
    output wire condPass
);

    // A zero creg field means the store is unconditional.
    assign condPass = (condField == 3'h0) |
        (zeroTest ? condRegIsZero : ~condRegIsZero);

endmodule // sbd_cond_eval

/* src/sbd_addr_arith.v */
// Adder of the address generator with linear and circular modes.
// Assumes the offset is already scaled; block size is 2 to the exp+1.
`timescale 1ns/1ps
module sbd_addr_arith
#(
    parameter AW = 32
)
(
    input wire [AW-1:0] base,
    input wire [AW-1:0] offset,
    input wire subtract,
    input wire circular,
    input wire [4:0] blockExp,
    output wire [AW-1:0] result
);

    wire [AW:0] blockSize;
    wire [AW-1:0] blockMask;
    wire [AW-1:0] linearSum;

    assign blockSize = {{AW{1'b0}}, 1'b1} << ({1'b0, blockExp} + 6'h01);
    assign blockMask = blockSize[AW-1:0] - {{(AW-1){1'b0}}, 1'b1};
    assign linearSum = subtract ? base - offset : base + offset;
    // Circular mode keeps the upper bits of the base and wraps the rest.
    assign result = circular ?
        ((base & ~blockMask) | (linearSum & blockMask)) : linearSum;

endmodule // sbd_addr_arith

/* src/sbd_store_agen.v */
// Decode and address generation of byte and doubleword stores.
// Assumes register files answer reads in the same cycle and the memory
// pipeline accepts one registered store request per cycle.
`timescale 1ns/1ps
`include "sbd_store_regs.vh"
module sbd_store_agen
(
    input wire core_clk,
    input wire reset,
    input wire instrValid,
    input wire [31:0] instrWord,
    input wire condRegIsZero,
    input wire [31:0] addressModeReg,
    input wire [31:0] baseRegData,
    input wire [31:0] offsetRegData,
    input wire [31:0] srcLoData,
    input wire [31:0] srcHiData,
    output wire [2:0] condRegSel,
    output wire baseFileB,
    output wire [4:0] baseRegIdx,
    output wire [4:0] offsetRegIdx,
    output wire srcFileB,
    output wire [4:0] srcLoIdx,
    output wire [4:0] srcHiIdx,
    output reg memWrite_q,
    output reg [31:0] memAddr_q,
    output reg [63:0] memData_q,
    output reg [7:0] memByteEn_q,
    output reg unitSideTwo_q,
    output reg illegalMode_q,
    output reg baseWrEn_q,
    output reg baseWrFileB_q,
    output reg [4:0] baseWrIdx_q,
    output reg [31:0] baseWrData_q
);

    wire isByteShort;
    wire isDword;
    wire isLong;
    wire [3:0] modeField;
    wire modeLegal;
    wire regOffset;
    wire addOffset;
    wire modifyBase;
    wire postMode;
    wire sideBit;
    wire condPass;
    wire shortForm;
    wire doStore;
    wire [31:0] rawOffset;
    wire [31:0] scaledOffset;
    wire circCandidate;
    wire [2:0] amrSlot;
    reg [1:0] amrField;
    reg useCircular;
    reg [4:0] blockExp;
    wire [31:0] agenResult;
    wire [31:0] accessAddr;
    wire [7:0] storeByte;
    reg memWrite_d;
    reg [31:0] memAddr_d;
    reg [63:0] memData_d;
    reg [7:0] memByteEn_d;
    reg unitSideTwo_d;
    reg illegalMode_d;
    reg baseWrEn_d;
    reg baseWrFileB_d;
    reg [4:0] baseWrIdx_d;
    reg [31:0] baseWrData_d;

    // Opcode recognition on the fixed low bits.
    assign isByteShort = ~instrWord[`SBD_DWBIT] &
        (instrWord[`SBD_OPC_MSB:`SBD_OPC_LSB] == `SBD_OPC_BYTE);
    assign isDword = instrWord[`SBD_DWBIT] &
        (instrWord[`SBD_OPC_MSB:`SBD_OPC_LSB] == `SBD_OPC_DWORD);
    assign isLong =
        (instrWord[`SBD_OPC_MSB:`SBD_OPC_LSB] == `SBD_OPC_LONG);
    assign shortForm = isByteShort | isDword;

    // Addressing mode fields of the short forms.
    assign modeField = instrWord[`SBD_MODE_MSB:`SBD_MODE_LSB];
    assign modeLegal = modeField[`SBD_MODE_MODIFY] |
        ~modeField[`SBD_MODE_POST];
    assign regOffset = modeField[`SBD_MODE_REGOFF];
    assign addOffset = modeField[`SBD_MODE_ADD];
    assign modifyBase = modeField[`SBD_MODE_MODIFY];
    assign postMode = modeField[`SBD_MODE_MODIFY] &
        modeField[`SBD_MODE_POST];
    assign sideBit = instrWord[`SBD_YBIT];

    sbd_cond_eval condEval
    (
        .condField(instrWord[`SBD_CREG_MSB:`SBD_CREG_LSB]),
        .zeroTest(instrWord[`SBD_ZBIT]),
        .condRegIsZero(condRegIsZero),
        .condPass(condPass)
    );

    assign condRegSel = instrWord[`SBD_CREG_MSB:`SBD_CREG_LSB];
    assign doStore = instrValid & condPass &
        ((shortForm & modeLegal) | isLong);

    // Register file read ports, all read in the first execute stage.
    assign baseFileB = isLong ? 1'b1 : sideBit;
    assign baseRegIdx = isLong ?
        (sideBit ? `SBD_FIXED_BASE_SECOND : `SBD_FIXED_BASE_FIRST) :
        instrWord[`SBD_BASE_MSB:`SBD_BASE_LSB];
    assign offsetRegIdx = instrWord[`SBD_OFF_MSB:`SBD_OFF_LSB];
    assign srcFileB = instrWord[`SBD_SBIT];
    // A pair takes the named even register low and the odd one high.
    assign srcLoIdx = isDword ?
        {instrWord[`SBD_SRC_MSB:`SBD_SRC_LSB+1], 1'b0} :
        instrWord[`SBD_SRC_MSB:`SBD_SRC_LSB];
    assign srcHiIdx = {instrWord[`SBD_SRC_MSB:`SBD_SRC_LSB+1], 1'b1};

    // Offset selection and scaling by the access size.
    assign rawOffset = isLong ?
        {17'h00000, instrWord[`SBD_LCST_MSB:`SBD_LCST_LSB]} :
        (regOffset ? offsetRegData :
        {27'h0000000, instrWord[`SBD_OFF_MSB:`SBD_OFF_LSB]});
    assign scaledOffset = isDword ?
        (rawOffset << `SBD_DW_SHIFT) :
        (rawOffset << `SBD_BYTE_SHIFT);

    // Circular mode is possible only for short forms on base 4 to 7.
    assign circCandidate = shortForm &
        (baseRegIdx[4:2] == `SBD_CIRC_BASE_HI);
    assign amrSlot = {baseFileB, baseRegIdx[1:0]};

    always @*
    begin
        amrField = addressModeReg[{amrSlot, 1'b0} +: 2];
        useCircular = 1'b0;
        blockExp = addressModeReg[`SBD_AMR_BK0_LSB +: 5];
        case (amrField)
            `SBD_AMR_BK0:
            begin
                useCircular = circCandidate;
            end
            `SBD_AMR_BK1:
            begin
                useCircular = circCandidate;
                blockExp = addressModeReg[`SBD_AMR_BK1_LSB +: 5];
            end
            default:
            begin
                useCircular = 1'b0;
            end
        endcase
    end

    sbd_addr_arith #(
        .AW(32)
    ) addrArith
    (
        .base(baseRegData),
        .offset(scaledOffset),
        .subtract(~isLong & ~addOffset),
        .circular(useCircular),
        .blockExp(blockExp),
        .result(agenResult)
    );

    // Post modes access the old base; all other modes the new address.
    assign accessAddr = (shortForm & postMode) ?
        baseRegData : agenResult;
    assign storeByte = srcLoData[7:0];

    always @*
    begin
        memWrite_d = doStore;
        memAddr_d = memAddr_q;
        memData_d = memData_q;
        memByteEn_d = `SBD_RST_BE;
        unitSideTwo_d = unitSideTwo_q;
        illegalMode_d = instrValid & shortForm & ~modeLegal;
        baseWrEn_d = 1'b0;
        baseWrFileB_d = baseWrFileB_q;
        baseWrIdx_d = baseWrIdx_q;
        baseWrData_d = baseWrData_q;
        if (doStore)
        begin
            memAddr_d = accessAddr;
            unitSideTwo_d = isLong ? 1'b1 : sideBit;
            if (isDword)
            begin
                memData_d = {srcHiData, srcLoData};
                memByteEn_d = `SBD_BE_ALL;
            end
            else
            begin
                memData_d = {8{storeByte}};
                memByteEn_d = `SBD_BE_ONE << accessAddr[2:0];
            end
            if (shortForm & modifyBase)
            begin
                baseWrEn_d = 1'b1;
                baseWrFileB_d = baseFileB;
                baseWrIdx_d = baseRegIdx;
                baseWrData_d = agenResult;
            end
        end
    end

    // One registered stage ends the first execute stage.
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            memWrite_q <= 1'b0;
            memAddr_q <= `SBD_RST_ADDR;
            memData_q <= `SBD_RST_DATA;
            memByteEn_q <= `SBD_RST_BE;
            unitSideTwo_q <= 1'b0;
            illegalMode_q <= 1'b0;
            baseWrEn_q <= 1'b0;
            baseWrFileB_q <= 1'b0;
            baseWrIdx_q <= 5'h00;
            baseWrData_q <= `SBD_RST_ADDR;
        end
        else
        begin
            memWrite_q <= memWrite_d;
            memAddr_q <= memAddr_d;
            memData_q <= memData_d;
            memByteEn_q <= memByteEn_d;
            unitSideTwo_q <= unitSideTwo_d;
            illegalMode_q <= illegalMode_d;
            baseWrEn_q <= baseWrEn_d;
            baseWrFileB_q <= baseWrFileB_d;
            baseWrIdx_q <= baseWrIdx_d;
            baseWrData_q <= baseWrData_d;
        end
    end

endmodule // sbd_store_agen

/* tb/sbd_store_agen_asserts.sv */
// Port checker of the store address generator.
// Bound to sbd_store_agen; sees only its ports, one clock domain.
`timescale 1ns/1ps
module sbd_store_agen_asserts
(
    input logic core_clk,
    input logic reset,
    input logic instrValid,
    input logic [31:0] instrWord,
    input logic condRegIsZero,
    input logic [31:0] baseRegData,
    input logic baseFileB,
    input logic [4:0] baseRegIdx,
    input logic memWrite_q,
    input logic [31:0] memAddr_q,
    input logic [63:0] memData_q,
    input logic [7:0] memByteEn_q,
    input logic unitSideTwo_q,
    input logic illegalMode_q,
    input logic baseWrEn_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    wire [3:0] md = instrWord[12:9];
    wire isLong = instrWord[6:2] == 5'h0f;
    wire isShort = (instrWord[6:2] == 5'h0d && !instrWord[8])
        || (instrWord[6:2] == 5'h11 && instrWord[8]);
    wire pass = instrWord[31:29] == 3'h0 || instrWord[28] == condRegIsZero;
    wire rsv = !md[3] && md[1];
    wire take = instrValid && pass && (isLong || (isShort && !rsv));
    sequence sTake;
        take;
    endsequence
    sequence sPost;
        take && isShort && md[3] && md[1];
    endsequence
    AST_ANSWER: assert property (sTake |=> memWrite_q)
        else $error("store not issued one cycle after decode");
    AST_BE_LANE: assert property (memWrite_q && memByteEn_q != 8'hff
        |-> memByteEn_q == 8'h01 << memAddr_q[2:0])
        else $error("byte lane does not match address");
    AST_BYTE_REPL: assert property (memWrite_q && memByteEn_q != 8'hff
        |-> memData_q == {8{memData_q[7:0]}})
        else $error("byte data not replicated");
    AST_LONG_SIDE: assert property (take && isLong
        |=> unitSideTwo_q && !baseWrEn_q)
        else $error("long form not on side two or wrote base");
    AST_LONG_BASE: assert property (isLong |-> baseFileB
        && baseRegIdx == {4'h7, instrWord[7]})
        else $error("long form base register wrong");
    AST_SIDE_SEL: assert property (isShort |-> baseFileB == instrWord[7]
        && baseRegIdx == instrWord[22:18])
        else $error("base file or index wrong");
    AST_POST_ADDR: assert property (sPost
        |=> memAddr_q == $past(baseRegData) && baseWrEn_q)
        else $error("post mode did not send old base");
    AST_REFUSE: assert property (instrValid && isShort && rsv
        |=> illegalMode_q && !memWrite_q)
        else $error("reserved mode not refused");
    AST_COND_FAIL: assert property (instrValid && !pass
        |=> !memWrite_q)
        else $error("store issued with failing condition");
endmodule // sbd_store_agen_asserts

bind sbd_store_agen sbd_store_agen_asserts chk (.core_clk, .reset,
    .instrValid, .instrWord, .condRegIsZero, .baseRegData, .baseFileB,
    .baseRegIdx, .memWrite_q, .memAddr_q, .memData_q, .memByteEn_q,
    .unitSideTwo_q, .illegalMode_q, .baseWrEn_q);

/* tb/sbd_regfile_model.sv */
// Register file and condition model answering operand reads.
// The bench loads rf and condZero; reads answer in the same cycle.
`timescale 1ns/1ps
module sbd_regfile_model
(
    input logic baseFileB,
    input logic [4:0] baseRegIdx,
    input logic [4:0] offsetRegIdx,
    input logic srcFileB,
    input logic [4:0] srcLoIdx,
    input logic [4:0] srcHiIdx,
    input logic [2:0] condRegSel,
    output logic condRegIsZero,
    output logic [31:0] baseRegData,
    output logic [31:0] offsetRegData,
    output logic [31:0] srcLoData,
    output logic [31:0] srcHiData
);
    logic [31:0] rf [0:63];
    logic [7:0] condZero;
    // Base values are kept on eight-byte boundaries.
    assign baseRegData = rf[{baseFileB, baseRegIdx}] & 32'hfffffff8;
    assign offsetRegData = rf[{baseFileB, offsetRegIdx}];
    assign srcLoData = rf[{srcFileB, srcLoIdx}];
    assign srcHiData = rf[{srcFileB, srcHiIdx}];
    assign condRegIsZero = condZero[condRegSel];
endmodule // sbd_regfile_model

/* tb/sbd_store_agen_bench.sv */
// Random self-checking bench of the store address generator.
// Compares every cycle against a model; register files in rfm.
`timescale 1ns/1ps
module sbd_store_agen_bench;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic instrValid = 1'b0;
    logic [31:0] instrWord = 32'h0;
    logic [31:0] addressModeReg = 32'h0;
    wire condRegIsZero, baseFileB, srcFileB, memWrite_q, unitSideTwo_q;
    wire illegalMode_q, baseWrEn_q, baseWrFileB_q;
    wire [31:0] baseRegData, offsetRegData, srcLoData, srcHiData;
    wire [31:0] memAddr_q, baseWrData_q;
    wire [63:0] memData_q;
    wire [7:0] memByteEn_q;
    wire [4:0] baseRegIdx, offsetRegIdx, srcLoIdx, srcHiIdx, baseWrIdx_q;
    wire [2:0] condRegSel;
    integer err_count = 0;
    integer checked = 0;
    integer seed = 32'hb55e;
    integer i;
    logic eW, eIll, eWb, eSide, lng, sh, dw, fb;
    logic [7:0] eBe;
    logic [31:0] eAddr, b, o, c, w, r, lo, hi;
    logic [63:0] eData;
    logic [37:0] eWr;
    logic [32:0] m;
    logic [1:0] k;
    always #5 core_clk = ~core_clk;
    sbd_store_agen dut (.core_clk, .reset, .instrValid, .instrWord,
        .condRegIsZero, .addressModeReg, .baseRegData, .offsetRegData,
        .srcLoData, .srcHiData, .condRegSel, .baseFileB, .baseRegIdx,
        .offsetRegIdx, .srcFileB, .srcLoIdx, .srcHiIdx, .memWrite_q,
        .memAddr_q, .memData_q, .memByteEn_q, .unitSideTwo_q,
        .illegalMode_q, .baseWrEn_q, .baseWrFileB_q, .baseWrIdx_q,
        .baseWrData_q);
    sbd_regfile_model rfm (.baseFileB, .baseRegIdx, .offsetRegIdx,
        .srcFileB, .srcLoIdx, .srcHiIdx, .condRegSel, .condRegIsZero,
        .baseRegData, .offsetRegData, .srcLoData, .srcHiData);
    task results;
        if (err_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input string what, input logic [63:0] e, input logic [63:0] g);
        checked = checked + 1;
        if (g !== e)
        begin
            err_count = err_count + 1;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task predict;
        dw = w[6:2] == 5'h11 && w[8];
        lng = w[6:2] == 5'h0f;
        sh = dw || (w[6:2] == 5'h0d && !w[8]);
        eIll = instrValid && !reset && sh && !w[12] && w[10];
        eW = instrValid && !reset && (lng || (sh && !eIll)) && (w[31:29] == 0
            || w[28] == rfm.condZero[w[31:29]]);
        fb = lng || w[7];
        b = rfm.rf[{fb, lng ? {4'h7, w[7]} : w[22:18]}] & 32'hfffffff8;
        if (lng) o = {17'h0, w[22:8]};
        else if (w[11]) o = rfm.rf[{fb, w[17:13]}];
        else o = {27'h0, w[17:13]};
        if (dw) o = o << 3;
        c = (w[9] || lng) ? b + o : b - o;
        k = addressModeReg[{fb, w[19:18], 1'b0} +: 2];
        m = (33'h1 << ((k[0] ? addressModeReg[20:16]
            : addressModeReg[25:21]) + 6'd1)) - 33'h1;
        if (!lng && w[22:20] == 3'h1 && k[0] != k[1])
            c = (b & ~m[31:0]) | (c & m[31:0]);
        eAddr = (w[10] && !lng) ? b : c;
        eWb = eW && sh && w[12];
        eWr = {fb, w[22:18], c};
        lo = rfm.rf[{w[1], w[27:24], w[23] && !dw}];
        hi = rfm.rf[{w[1], w[27:24], 1'b1}];
        eData = dw ? {hi, lo} : {8{lo[7:0]}};
        eBe = !eW ? 8'h00 : dw ? 8'hff : 8'h01 << eAddr[2:0];
        eSide = fb;
    endtask
    initial
    begin
        #400000;
        err_count = err_count + 1;
        results;
    end
    initial
    begin
        for (i = 0; i < 64; i = i + 1)
            rfm.rf[i] = $random(seed);
        rfm.condZero = 8'h0f;
        w = 32'h0;
        predict;
        repeat (4) @(posedge core_clk);
        for (i = 0; i < 3000; i = i + 1)
        begin
            @(posedge core_clk);
            #1;
            chk("memWrite", eW, memWrite_q);
            chk("byteEn", eBe, memByteEn_q);
            chk("illegal", eIll, illegalMode_q);
            chk("baseWrEn", eWb, baseWrEn_q);
            if (eW)
            begin
                chk("addr", eAddr, memAddr_q);
                chk("data", eData, memData_q);
                chk("side", eSide, unitSideTwo_q);
            end
            if (eWb)
                chk("wb", eWr,
                    {baseWrFileB_q, baseWrIdx_q, baseWrData_q});
            w = $random(seed);
            r = $random(seed);
            w[6:2] = r[1:0] == 0 ? 5'h0d : r[1:0] == 1 ? 5'h11
                : r[1:0] == 2 ? 5'h0f : w[6:2];
            if (r[2])
                w[8] = w[6:2] == 5'h11;
            if (r[3])
                w[22:20] = 3'h1;
            if (r[4])
                w[31:29] = 3'h0;
            if (r[9:6] == 0)
                addressModeReg = $random(seed);
            if (r[15:11] == 0)
                rfm.condZero = r[23:16];
            reset = i == 1500;
            instrValid = r[5] | r[10];
            instrWord = w;
            predict;
        end
        results;
    end
endmodule // sbd_store_agen_bench
